// *** cic_defs.vh ***
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH

// ==========================================================
// i/o port map
// ==========================================================
`define CIC_PRI_EVEN 8'h20
`define CIC_PRI_ODD 8'h21
`define CIC_SEC_EVEN 8'ha0
`define CIC_SEC_ODD 8'ha1

// ==========================================================
// reset values and spurious level code
// ==========================================================
`define CIC_MODE_RST 8'h01
`define CIC_MASK_RST 8'h00
`define CIC_PRIO_RST 3'h7
`define CIC_SPURIOUS 3'h7

// ==========================================================
// field positions
// ==========================================================
`define CIC_INIT_BIT 4
`define CIC_SEL_BIT 3
`define CIC_SL_BIT 6
`define CIC_MODE_AUTO_END_OF_INTERRUPT 1
`define CIC_MODE_SPECIAL_NESTED_MODE 4

// ==========================================================
// eoi / priority command codes, bits 7:5
// ==========================================================
`define CIC_CMD_ROT_AUTO_END_OF_INTERRUPT_CLR 3'h0
`define CIC_CMD_EOI_NS 3'h1
`define CIC_CMD_NOP 3'h2
`define CIC_CMD_EOI_SP 3'h3
`define CIC_CMD_ROT_AUTO_END_OF_INTERRUPT_SET 3'h4
`define CIC_CMD_ROT_NS 3'h5
`define CIC_CMD_SET_PRIO 3'h6
`define CIC_CMD_ROT_SP 3'h7

// ==========================================================
// initialization step encoding
// ==========================================================
`define CIC_STEP_RUN 2'h0
`define CIC_STEP_VBASE 2'h1
`define CIC_STEP_CASC 2'h2
`define CIC_STEP_MODE 2'h3

`endif

// *** cic_sync.v ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// three-stage pin synchroniser with agreement filter
// ==========================================================
module cic_sync #(
   parameter W = 16
) (
   input wire clk_sys, // system clock
   input wire rst, // async reset, active high
   input wire [W-1:0] din, // raw pin levels
   output reg [W-1:0] dout // filtered level
);

   genvar b;
   generate
      for (b = 0; b < W; b = b + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         // first stage feeds only the second; output moves once stages 2 and 3 agree
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               dout[b] <= 1'b0;
            end else begin
               s1_r <= din[b];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  dout[b] <= s3_r;
               end
            end
         end
      end
   endgenerate

endmodule // cic_sync

`default_nettype wire

// *** cic_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "cic_defs.vh"

// Overview of operation
// - servicing primary line 2 hands second-pulse vector to secondary unit
// - secondary interrupt output enters primary as line 2, never the processor
// - line 2 winning drives cascade code from first to second pulse trailing edge
// - secondary compares cascade code to its id, drives vector on match
// - mode-setup word resets to 01h
// - mode-setup bit 1 selects automatic end-of-interrupt, else normal
// - mode-setup bit 4 selects special fully nested mode
// - mask word write sets or clears each line mask; resets to zero
// - odd port read returns that unit's mask register directly
// - masked lines do not set request bits; unmasking accepts again
// - masking primary line 2 blocks all secondary requests
// - masking a high-priority line leaves lower lines resolving normally
// - command bits 7:5 decode eoi, rotate and set-priority operations
// - low three command bits select level only when bit 6 set
// - after reset, fully nested, non-specific eoi, no rotation
// - even-port write is a command only with bits 4 and 3 zero
// - even-port write with bit 4 starts three-word odd-port initialization
// - vector joins five-bit base with three-bit level code
module cic_top (
   input wire clk_sys, // system clock, 250 MHz
   input wire rst, // async reset, active high
   input wire [7:0] io_addr, // i/o port address
   input wire io_wr, // i/o write strobe, one cycle
   input wire io_rd, // i/o read strobe, one cycle
   input wire [7:0] io_wdata, // i/o write data
   output reg [7:0] io_rdata, // i/o read data, one cycle after io_rd
   input wire [15:0] irq_in, // request pins, bit 2 unused (cascade)
   input wire int_acknowledge_pulse_n, // acknowledge pulse from processor logic, low active
   output reg int_out, // interrupt request to processor
   output reg [7:0] ack_vector, // vector during second acknowledge
   output reg ack_vector_oe, // high while ack_vector is driven
   output reg [2:0] cas_code, // internal cascade lines
   output reg cas_oe // high while cascade code is broadcast
);

   // ==========================================================
   // acknowledge sequencer states
   // ==========================================================
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_ACK1 = 4'b0010;
   localparam [3:0] ST_GAP = 4'b0100;
   localparam [3:0] ST_ACK2 = 4'b1000;

   wire [15:0] irq_sync;
   wire [15:0] req_all;
   wire [1:0] int_req;
   wire [5:0] top_lvl;
   wire [15:0] imr_all;
   wire [15:0] irr_all;
   wire [9:0] vbase_all;
   wire [15:0] casc_all;
   wire [1:0] take;
   wire [5:0] take_lvl;
   reg [3:0] st_r;
   reg [3:0] st_nxt;
   reg int_acknowledge_pulse_q_r;
   reg pri_cas_r;
   reg [2:0] pri_lvl_r;
   reg pri_took_r;
   reg sec_took_r;
   wire int_acknowledge_pulse_fall;
   wire int_acknowledge_pulse_rise;
   wire take1;
   wire end1;
   wire take2;
   wire end2;
   wire sec_match;
   wire [1:0] svc_end;

   // ==========================================================
   // request pins into the clock domain
   // ==========================================================
   cic_sync #(
      .W(16)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(irq_in),
      .dout(irq_sync)
   );

   // secondary output cascades into primary line 2, never straight out
   assign req_all = {irq_sync[15:8], irq_sync[7:3], int_req[1], irq_sync[1:0]};

   // ==========================================================
   // acknowledge sequencer
   // ==========================================================
   assign int_acknowledge_pulse_fall = int_acknowledge_pulse_q_r & ~int_acknowledge_pulse_n;
   assign int_acknowledge_pulse_rise = ~int_acknowledge_pulse_q_r & int_acknowledge_pulse_n;
   assign take1 = (st_r == ST_IDLE) && int_acknowledge_pulse_fall;
   assign end1 = (st_r == ST_ACK1) && int_acknowledge_pulse_rise;
   assign take2 = (st_r == ST_GAP) && int_acknowledge_pulse_fall;
   assign end2 = (st_r == ST_ACK2) && int_acknowledge_pulse_rise;

   // next state follows the pulse edges only
   always @* begin
      case (st_r)
         ST_IDLE: st_nxt = int_acknowledge_pulse_fall ? ST_ACK1 : ST_IDLE;
         ST_ACK1: st_nxt = int_acknowledge_pulse_rise ? ST_GAP : ST_ACK1;
         ST_GAP: st_nxt = int_acknowledge_pulse_fall ? ST_ACK2 : ST_GAP;
         ST_ACK2: st_nxt = int_acknowledge_pulse_rise ? ST_IDLE : ST_ACK2;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // secondary only answers when the broadcast code is its own id
   assign sec_match = cas_oe && (cas_code == casc_all[10:8]);

   // primary takes at first pulse, secondary at second pulse on a match
   assign take[0] = take1 && int_req[0];
   assign take_lvl[2:0] = top_lvl[2:0];
   assign take[1] = take2 && sec_match && int_req[1];
   assign take_lvl[5:3] = top_lvl[5:3];
   assign svc_end = {end2 & sec_took_r, end2 & pri_took_r};

   // sequencer registers and the pins it drives
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         int_acknowledge_pulse_q_r <= 1'b1;
         pri_cas_r <= 1'b0;
         pri_lvl_r <= 3'h0;
         pri_took_r <= 1'b0;
         sec_took_r <= 1'b0;
         cas_code <= 3'h0;
         cas_oe <= 1'b0;
         ack_vector <= 8'h00;
         ack_vector_oe <= 1'b0;
         int_out <= 1'b0;
      end else begin
         st_r <= st_nxt;
         int_acknowledge_pulse_q_r <= int_acknowledge_pulse_n;
         int_out <= int_req[0];
         if (take1) begin
            // no pending line at this point reads as a spurious lowest level
            pri_lvl_r <= int_req[0] ? top_lvl[2:0] : `CIC_SPURIOUS;
            pri_took_r <= int_req[0];
            pri_cas_r <= int_req[0] && casc_all[top_lvl[2:0]];
            sec_took_r <= 1'b0;
         end
         if (end1 && pri_cas_r) begin
            cas_code <= pri_lvl_r;
            cas_oe <= 1'b1;
         end
         if (take2) begin
            sec_took_r <= take[1];
            if (sec_match) begin
               ack_vector <= {vbase_all[9:5], top_lvl[5:3]};
               ack_vector_oe <= 1'b1;
            end else if (!pri_cas_r) begin
               ack_vector <= {vbase_all[4:0], pri_lvl_r};
               ack_vector_oe <= 1'b1;
            end
         end
         if (end2) begin
            // cascade code released on the second trailing edge
            cas_oe <= 1'b0;
            cas_code <= 3'h0;
            ack_vector_oe <= 1'b0;
            pri_took_r <= 1'b0;
            sec_took_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // the two controller units
   // ==========================================================
   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1) begin : g_unit
         localparam [7:0] EVEN = (u == 0) ? `CIC_PRI_EVEN : `CIC_SEC_EVEN;
         localparam [7:0] ODD = (u == 0) ? `CIC_PRI_ODD : `CIC_SEC_ODD;
         reg [7:0] irr_r;
         reg [7:0] isr_r;
         reg [7:0] imr_r;
         reg [7:0] last_r;
         reg [7:0] casc_r;
         reg [7:0] mode_r;
         reg [4:0] vbase_r;
         reg [2:0] prio_r;
         reg [2:0] svc_lvl_r;
         reg [1:0] step_r;
         reg rot_auto_end_of_interrupt_r;
         reg p_hit;
         reg s_hit;
         reg [2:0] p_lvl;
         reg [2:0] s_lvl;
         reg [2:0] p_rank;
         reg [2:0] s_rank;
         reg [2:0] idx;
         reg [7:0] isr_clr;
         integer k;
         wire [7:0] req;
         wire [7:0] pend;
         wire [7:0] irr_set;
         wire [7:0] irr_clr;
         wire [7:0] isr_set;
         wire wr_even;
         wire wr_odd;
         wire wr_init;
         wire wr_cmd;
         wire [2:0] cmd;
         wire [2:0] lsel;
         wire special_nested_mode;

         assign req = req_all[u*8 +: 8];
         assign wr_even = io_wr && (io_addr == EVEN);
         assign wr_odd = io_wr && (io_addr == ODD);
         assign wr_init = wr_even && io_wdata[`CIC_INIT_BIT];
         assign wr_cmd = wr_even && !io_wdata[`CIC_INIT_BIT] && !io_wdata[`CIC_SEL_BIT];
         assign cmd = io_wdata[7:5];
         // level bits only count when the select flag is set
         assign lsel = io_wdata[`CIC_SL_BIT] ? io_wdata[2:0] : s_lvl;
         assign special_nested_mode = mode_r[`CIC_MODE_SPECIAL_NESTED_MODE];

         // mask only hides its own line; others still resolve
         assign pend = irr_r & ~imr_r;
         // a rising request edge is latched only while unmasked
         assign irr_set = req & ~last_r & ~imr_r;
         assign irr_clr = take[u] ? (8'h01 << take_lvl[u*3 +: 3]) : 8'h00;
         assign isr_set = take[u] ? (8'h01 << take_lvl[u*3 +: 3]) : 8'h00;

         // scan from the line after the lowest-priority one
         always @* begin
            p_hit = 1'b0;
            s_hit = 1'b0;
            p_lvl = 3'h0;
            s_lvl = 3'h0;
            p_rank = 3'h0;
            s_rank = 3'h0;
            idx = 3'h0;
            for (k = 0; k < 8; k = k + 1) begin
               idx = prio_r + 3'h1 + k[2:0];
               if (!p_hit && pend[idx]) begin
                  p_hit = 1'b1;
                  p_lvl = idx;
                  p_rank = k[2:0];
               end
               if (!s_hit && isr_r[idx]) begin
                  s_hit = 1'b1;
                  s_lvl = idx;
                  s_rank = k[2:0];
               end
            end
         end

         // fully nested: only a strictly higher line interrupts, equal too in special mode
         assign int_req[u] = p_hit && (!s_hit || (p_rank < s_rank) || (special_nested_mode && p_rank == s_rank));
         assign top_lvl[u*3 +: 3] = p_lvl;
         assign imr_all[u*8 +: 8] = imr_r;
         assign irr_all[u*8 +: 8] = irr_r;
         assign vbase_all[u*5 +: 5] = vbase_r;
         assign casc_all[u*8 +: 8] = casc_r;

         // in-service clears from eoi commands and automatic eoi
         always @* begin
            isr_clr = 8'h00;
            if (wr_cmd) begin
               case (cmd)
                  `CIC_CMD_EOI_NS: isr_clr = s_hit ? (8'h01 << s_lvl) : 8'h00;
                  `CIC_CMD_ROT_NS: isr_clr = s_hit ? (8'h01 << s_lvl) : 8'h00;
                  `CIC_CMD_EOI_SP: isr_clr = 8'h01 << lsel;
                  `CIC_CMD_ROT_SP: isr_clr = 8'h01 << lsel;
                  default: isr_clr = 8'h00;
               endcase
            end
            if (svc_end[u] && mode_r[`CIC_MODE_AUTO_END_OF_INTERRUPT]) begin
               isr_clr = isr_clr | (8'h01 << svc_lvl_r);
            end
         end

         // unit register file and request state
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               irr_r <= 8'h00;
               isr_r <= 8'h00;
               imr_r <= `CIC_MASK_RST;
               last_r <= 8'h00;
               casc_r <= 8'h00;
               mode_r <= `CIC_MODE_RST;
               vbase_r <= 5'h00;
               prio_r <= `CIC_PRIO_RST;
               svc_lvl_r <= 3'h0;
               step_r <= `CIC_STEP_RUN;
               rot_auto_end_of_interrupt_r <= 1'b0;
            end else begin
               last_r <= req;
               // a new edge in the take cycle survives the clear
               irr_r <= (irr_r & ~irr_clr) | irr_set;
               isr_r <= (isr_r & ~isr_clr) | isr_set;
               if (take[u]) begin
                  svc_lvl_r <= take_lvl[u*3 +: 3];
               end
               if (svc_end[u] && mode_r[`CIC_MODE_AUTO_END_OF_INTERRUPT] && rot_auto_end_of_interrupt_r) begin
                  prio_r <= svc_lvl_r;
               end
               if (wr_init) begin
                  // restart: requests, in-service, mask, priority and rotation return to defaults
                  irr_r <= 8'h00;
                  isr_r <= 8'h00;
                  imr_r <= `CIC_MASK_RST;
                  prio_r <= `CIC_PRIO_RST;
                  rot_auto_end_of_interrupt_r <= 1'b0;
                  step_r <= `CIC_STEP_VBASE;
               end else if (wr_cmd) begin
                  case (cmd)
                     `CIC_CMD_ROT_NS: if (s_hit) prio_r <= s_lvl;
                     `CIC_CMD_ROT_SP: prio_r <= lsel;
                     `CIC_CMD_SET_PRIO: prio_r <= lsel;
                     `CIC_CMD_ROT_AUTO_END_OF_INTERRUPT_SET: rot_auto_end_of_interrupt_r <= 1'b1;
                     `CIC_CMD_ROT_AUTO_END_OF_INTERRUPT_CLR: rot_auto_end_of_interrupt_r <= 1'b0;
                     default: rot_auto_end_of_interrupt_r <= rot_auto_end_of_interrupt_r;
                  endcase
               end
               if (wr_odd) begin
                  case (step_r)
                     `CIC_STEP_VBASE: begin
                        vbase_r <= io_wdata[7:3];
                        step_r <= `CIC_STEP_CASC;
                     end
                     `CIC_STEP_CASC: begin
                        casc_r <= io_wdata;
                        step_r <= `CIC_STEP_MODE;
                     end
                     `CIC_STEP_MODE: begin
                        mode_r <= io_wdata;
                        step_r <= `CIC_STEP_RUN;
                     end
                     default: imr_r <= io_wdata;
                  endcase
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // register reads
   // ==========================================================
   // odd ports show the mask with no select step; even ports show requests
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         case (io_addr)
            `CIC_PRI_ODD: io_rdata <= imr_all[7:0];
            `CIC_SEC_ODD: io_rdata <= imr_all[15:8];
            `CIC_PRI_EVEN: io_rdata <= irr_all[7:0];
            `CIC_SEC_EVEN: io_rdata <= irr_all[15:8];
            default: io_rdata <= 8'h00;
         endcase
      end
   end

endmodule // cic_top

`default_nettype wire

// *** cic_top_checker.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// port checker for cic_top
// ==========================================================
module cic_top_checker (
   input wire logic clk_sys, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [7:0] io_addr, // port address
   input wire logic io_wr, // write strobe
   input wire logic io_rd, // read strobe
   input wire logic [7:0] io_wdata, // write data
   input wire logic [7:0] io_rdata, // read data
   input wire logic int_acknowledge_pulse_n, // acknowledge pulse
   input wire logic [7:0] ack_vector, // vector
   input wire logic ack_vector_oe, // vector driven
   input wire logic [2:0] cas_code, // cascade lines
   input wire logic cas_oe // cascade broadcast
);
   logic [3:0] step_r;
   logic [15:0] mask_r;
   logic [9:0] base_r;
   wire mapped = (io_addr[6:1] == 6'h10);
   wire u = io_addr[7];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // shadow of init step, vector base and mask per unit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         step_r <= 4'h0;
         mask_r <= 16'h0000;
         base_r <= 10'h000;
      end else if (io_wr && mapped && !io_addr[0] && io_wdata[4]) begin
         step_r[u*2 +: 2] <= 2'h3;
         mask_r[u*8 +: 8] <= 8'h00;
      end else if (io_wr && mapped && io_addr[0]) begin
         if (step_r[u*2 +: 2] == 2'h3)
            base_r[u*5 +: 5] <= io_wdata[7:3];
         if (step_r[u*2 +: 2] != 2'h0)
            step_r[u*2 +: 2] <= step_r[u*2 +: 2] - 2'h1;
         else
            mask_r[u*8 +: 8] <= io_wdata;
      end
   end

   pri_mask_a: assert property (io_rd && io_addr == 8'h21 |=> io_rdata == $past(mask_r[7:0]))
      else $error("primary mask read wrong");
   sec_mask_a: assert property (io_rd && io_addr == 8'ha1 |=> io_rdata == $past(mask_r[15:8]))
      else $error("secondary mask read wrong");
   unmapped_read_a: assert property (io_rd && !mapped |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   cas_code_a: assert property (cas_oe |-> cas_code == 3'h2)
      else $error("cascade code wrong");
   cas_start_a: assert property ($rose(cas_oe) |-> $past(int_acknowledge_pulse_n) && !$past(int_acknowledge_pulse_n, 2))
      else $error("cascade start misplaced");
   cas_hold_a: assert property (cas_oe && !int_acknowledge_pulse_n |=> cas_oe)
      else $error("cascade dropped in pulse");
   cas_end_a: assert property ($fell(cas_oe) |-> $fell(ack_vector_oe))
      else $error("cascade end misplaced");
   vec_start_a: assert property ($rose(ack_vector_oe) |-> !$past(int_acknowledge_pulse_n) && $past(int_acknowledge_pulse_n, 2))
      else $error("vector start misplaced");
   vec_end_a: assert property (ack_vector_oe && int_acknowledge_pulse_n |=> !ack_vector_oe)
      else $error("vector held too long");
   sec_vector_a: assert property (ack_vector_oe && cas_oe |-> ack_vector[7:3] == base_r[9:5])
      else $error("secondary vector base wrong");
   pri_vector_a: assert property (ack_vector_oe && !cas_oe |-> ack_vector[7:3] == base_r[4:0])
      else $error("primary vector base wrong");

   cover property ($rose(cas_oe));
   cover property (ack_vector_oe && !cas_oe);
   cover property (io_rd && io_addr == 8'h21);
endmodule // cic_top_checker

`default_nettype wire

// *** cic_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host processor acknowledge model
// ==========================================================
module cic_host_model (
   input wire logic clk_sys, // system clock
   input wire logic go, // start one two-pulse acknowledge
   input wire logic [3:0] width, // cycles per low and high phase
   input wire logic [7:0] ack_vector, // vector from block
   input wire logic ack_vector_oe, // vector driven
   input wire logic [2:0] cas_code, // cascade lines
   input wire logic cas_oe, // cascade broadcast
   output logic int_acknowledge_pulse_n, // acknowledge pulse, low active
   output logic busy, // sequence running
   output logic [7:0] vec_seen, // vector taken
   output logic [3:0] cas_seen // seen flag and code
);
   integer p;
   logic start_t;
   logic start_q;
   // two alternating pulses, each phase at least one cycle
   initial begin
      int_acknowledge_pulse_n = 1'b1;
      busy = 1'b0;
      start_t = 1'b0;
      forever begin
         @(posedge clk_sys);
         if (go === 1'b1) begin
            busy = 1'b1;
            start_t = ~start_t;
            for (p = 0; p < 2; p = p + 1) begin
               @(negedge clk_sys);
               int_acknowledge_pulse_n = 1'b0;
               repeat (width) @(negedge clk_sys);
               int_acknowledge_pulse_n = 1'b1;
               repeat (width) @(negedge clk_sys);
            end
            repeat (2) @(negedge clk_sys);
            busy = 1'b0;
         end
      end
   end

   // sample away from the edge that updates the outputs; one process owns the seen values
   always @(negedge clk_sys) begin
      start_q <= start_t;
      if (start_t !== start_q) begin
         vec_seen <= 8'hxx;
         cas_seen <= 4'h0;
      end else begin
         if (busy && ack_vector_oe)
            vec_seen <= ack_vector;
         if (busy && cas_oe)
            cas_seen <= {1'b1, cas_code};
      end
   end
endmodule // cic_host_model

`default_nettype wire

// *** cic_top_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// testbench top
// ==========================================================
module cic_top_tb_top;
   logic clk_sys;
   logic rst;
   logic [7:0] io_addr;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_wdata;
   logic [15:0] irq_in;
   logic go;
   logic [3:0] width;
   integer fails;
   integer checked;
   wire [7:0] io_rdata;
   wire int_acknowledge_pulse_n;
   wire int_out;
   wire [7:0] ack_vector;
   wire ack_vector_oe;
   wire [2:0] cas_code;
   wire cas_oe;
   wire busy;
   wire [7:0] vec_seen;
   wire [3:0] cas_seen;

   cic_top i_dut (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_in(irq_in), .int_acknowledge_pulse_n(int_acknowledge_pulse_n), .int_out(int_out),
      .ack_vector(ack_vector), .ack_vector_oe(ack_vector_oe), .cas_code(cas_code), .cas_oe(cas_oe));
   cic_host_model i_host (.clk_sys(clk_sys), .go(go), .width(width), .ack_vector(ack_vector),
      .ack_vector_oe(ack_vector_oe), .cas_code(cas_code), .cas_oe(cas_oe), .int_acknowledge_pulse_n(int_acknowledge_pulse_n),
      .busy(busy), .vec_seen(vec_seen), .cas_seen(cas_seen));

   // 250 mhz clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task chk(input [8*10-1:0] name, input [7:0] seen, input [7:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk_sys);
         io_addr = a;
         io_wdata = d;
         io_wr = 1'b1;
         @(negedge clk_sys);
         io_wr = 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [7:0] exp);
      begin
         @(negedge clk_sys);
         io_addr = a;
         io_rd = 1'b1;
         @(negedge clk_sys);
         io_rd = 1'b0;
         @(negedge clk_sys);
         chk("io_rdata", io_rdata, exp);
      end
   endtask

   task init(input [7:0] a, input [7:0] vb, input [7:0] cw, input [7:0] mw);
      begin
         wr(a, 8'h11);
         wr(a + 8'h01, vb);
         wr(a + 8'h01, cw);
         wr(a + 8'h01, mw);
      end
   endtask

   // pins held long enough to pass the synchroniser filter
   task irq(input [15:0] b);
      begin
         @(negedge clk_sys);
         irq_in = b;
         repeat (4) @(negedge clk_sys);
         irq_in = 16'h0000;
         repeat (6) @(negedge clk_sys);
      end
   endtask

   task int_chk(input e);
      integer i;
      begin
         for (i = 0; i < 40 && int_out !== 1'b1; i = i + 1)
            @(negedge clk_sys);
         chk("int_out", {7'h00, int_out}, {7'h00, e});
         // a request that never shows is a dead run
         if (e && int_out !== 1'b1)
            conclude;
      end
   endtask

   task ack(input [3:0] w, input [7:0] vexp, input [3:0] cexp);
      integer i;
      begin
         int_chk(1'b1);
         width = w;
         go = 1'b1;
         @(negedge clk_sys);
         go = 1'b0;
         for (i = 0; i < 100 && busy === 1'b1; i = i + 1)
            @(negedge clk_sys);
         chk("vector", vec_seen, vexp);
         chk("cascade", {4'h0, cas_seen}, {4'h0, cexp});
         chk("busy", {7'h00, busy}, 8'h00);
         if (busy === 1'b1)
            conclude;
      end
   endtask

   task conclude;
      begin
         $display("checks %0d mismatches %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      fails = fails + 1;
      conclude;
   end

   // main sequence
   initial begin
      rst = 1'b1;
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      irq_in = 16'h0000;
      go = 1'b0;
      width = 4'h1;
      fails = 0;
      checked = 0;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      rd(8'h21, 8'h00);
      rd(8'ha1, 8'h00);
      rd(8'h55, 8'h00);
      init(8'h20, 8'h08, 8'h04, 8'h01);
      init(8'ha0, 8'h70, 8'h02, 8'h01);
      wr(8'h21, 8'ha5);
      rd(8'h21, 8'ha5);
      wr(8'ha1, 8'h3c);
      rd(8'ha1, 8'h3c);
      wr(8'ha1, 8'h00);
      // lines 1 and 4 masked, 6 open
      wr(8'h21, 8'h12);
      irq(16'h0052);
      ack(4'h1, 8'h0e, 4'h0);
      wr(8'h20, 8'h20);
      int_chk(1'b0);
      wr(8'h21, 8'h00);
      irq(16'h0010);
      ack(4'h3, 8'h0c, 4'h0);
      // line 5 waits behind line 4 in service
      irq(16'h0020);
      int_chk(1'b0);
      wr(8'h20, 8'h28);
      int_chk(1'b0);
      wr(8'h20, 8'h40);
      wr(8'h20, 8'h65);
      int_chk(1'b0);
      wr(8'h20, 8'h64);
      ack(4'h1, 8'h0d, 4'h0);
      wr(8'h20, 8'ha0);
      irq(16'h0042);
      ack(4'h1, 8'h0e, 4'h0);
      wr(8'h20, 8'he6);
      wr(8'h20, 8'hc2);
      irq(16'h0008);
      ack(4'h1, 8'h0b, 4'h0);
      wr(8'h20, 8'h20);
      ack(4'h1, 8'h09, 4'h0);
      wr(8'h20, 8'h20);
      wr(8'h20, 8'hc7);
      // secondary line 8 races primary line 1
      irq(16'h0102);
      ack(4'h1, 8'h09, 4'h0);
      wr(8'h20, 8'h20);
      ack(4'h1, 8'h70, 4'ha);
      wr(8'ha0, 8'h20);
      wr(8'h20, 8'h20);
      irq(16'h0400);
      ack(4'h3, 8'h72, 4'ha);
      wr(8'ha0, 8'h20);
      wr(8'h20, 8'h20);
      // automatic end of interrupt on the primary
      wr(8'h21, 8'h5a);
      init(8'h20, 8'h08, 8'h04, 8'h03);
      rd(8'h21, 8'h00);
      wr(8'h20, 8'h80);
      irq(16'h0008);
      ack(4'h1, 8'h0b, 4'h0);
      // rotation in auto mode puts line 5 ahead of line 1
      irq(16'h0022);
      ack(4'h1, 8'h0d, 4'h0);
      ack(4'h1, 8'h09, 4'h0);
      wr(8'h20, 8'h00);
      // line 2 masked hides the secondary
      wr(8'h21, 8'h04);
      irq(16'h0200);
      int_chk(1'b0);
      // special nested mode lets line 3 interrupt its own service
      init(8'h20, 8'h08, 8'h04, 8'h11);
      irq(16'h0008);
      ack(4'h1, 8'h0b, 4'h0);
      irq(16'h0008);
      ack(4'h1, 8'h0b, 4'h0);
      conclude;
   end
endmodule // cic_top_tb_top

bind cic_top cic_top_checker i_chk (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
   .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .int_acknowledge_pulse_n(int_acknowledge_pulse_n), .ack_vector(ack_vector),
   .ack_vector_oe(ack_vector_oe), .cas_code(cas_code), .cas_oe(cas_oe));

`default_nettype wire
